// ---- core/mf_defs.svh ----
// constants for the multifunction compute issue datapath
`ifndef MF_DEFS_SVH
`define MF_DEFS_SVH

`define MF_DATA_W   32
`define MF_ACC_W    80
`define MF_REGS     16
`define MF_IDX_W    4
`define MF_SEL_W    2

// register file quarters, upper two index bits
`define MF_Q_MULT_X 2'h0
`define MF_Q_MULT_Y 2'h1
`define MF_Q_ALU_X  2'h2
`define MF_Q_ALU_Y  2'h3

// round-to-nearest: add half an lsb of the upper result word
`define MF_RND_ADD  80'h0000_0000_0000_8000_0000

// single precision float fields
`define MF_FP_BIAS  11'sh07f
`define MF_FP_EMAX  11'sh0ff
`define MF_FP_INF   31'h7f80_0000
`define MF_FIX_MAXE 11'sh01e
`define MF_FIX_POS  32'h7fff_ffff
`define MF_FIX_NEG  32'h8000_0000
`define MF_SIGN_BIT 32'h8000_0000

`endif

// ---- core/mf_pkg.sv ----
// types for the multifunction compute issue datapath
package mf_pkg;

    // multiplier half of the instruction
    typedef enum logic [2:0] {
        MUL_REG  = 3'b000,  // mult_dest_reg = x*y rounded
        MAC_ACC  = 3'b001,  // accumulator += x*y, unrounded
        MSUB_ACC = 3'b010,  // accumulator -= x*y, unrounded
        MAC_REG  = 3'b011,  // mult_dest_reg = accumulator + x*y rounded
        MSUB_REG = 3'b100   // mult_dest_reg = accumulator - x*y rounded
    } mult_mode_e;

    // alu half of the instruction
    typedef enum logic [3:0] {
        ALU_ADD    = 4'b0000,
        ALU_SUB    = 4'b0001,
        ALU_AVG    = 4'b0010,
        ALU_ADDSUB = 4'b0011,  // sum and difference, two destinations
        ALU_FLOAT  = 4'b0100,  // float only: fixed to float, scaled
        ALU_FIX    = 4'b0101,  // float only: float to fixed, scaled
        ALU_ABS    = 4'b0110,  // float only
        ALU_MAX    = 4'b0111,  // float only
        ALU_MIN    = 4'b1000   // float only
    } alu_mode_e;

endpackage

// ---- core/mf_fp_unit.sv ----
// single precision float multiplier and alu for multifunction issue
`timescale 1ns/1ps
`include "mf_defs.svh"

module mf_fp_unit (
    input  wire logic [31:0] mx_i,       // multiplier x operand
    input  wire logic [31:0] my_i,       // multiplier y operand
    input  wire logic [31:0] ax_i,       // alu x operand
    input  wire logic [31:0] ay_i,       // alu y operand / scale
    input  wire logic [3:0]  alu_mode_i, // alu operation select
    output logic      [31:0] prod_o,     // product
    output logic      [31:0] alu_o,      // alu result
    output logic      [31:0] alu2_o      // difference for dual add/sub
);

    // pack with flush-to-zero and overflow to infinity
    function automatic logic [31:0] fpack(input logic sg,
                                          input logic signed [10:0] e,
                                          input logic [22:0] fr);
        begin
            if (e <= 11'sh000)
                fpack = {sg, 31'h0000_0000};
            else if (e >= `MF_FP_EMAX)
                fpack = {sg, `MF_FP_INF};
            else
                fpack = {sg, e[7:0], fr};
        end
    endfunction

    // truncating add; a denormal larger input gives zero, a denormal smaller input adds its fraction without the hidden bit
    function automatic logic [31:0] fadd(input logic [31:0] a,
                                         input logic [31:0] b);
        logic [31:0]        big;
        logic [31:0]        sml;
        logic [7:0]         d;
        logic [27:0]        mb;
        logic [27:0]        ms;
        logic [27:0]        s;
        logic signed [10:0] e;
        integer             i;
        begin
            if (a[30:0] >= b[30:0]) begin
                big = a;
                sml = b;
            end else begin
                big = b;
                sml = a;
            end
            d  = big[30:23] - sml[30:23];
            mb = {1'b0, (big[30:23] != 8'h00), big[22:0], 3'b000};
            ms = {1'b0, (sml[30:23] != 8'h00), sml[22:0], 3'b000};
            ms = (d > 8'd26) ? 28'h000_0000 : (ms >> d);
            s  = (big[31] == sml[31]) ? mb + ms : mb - ms;
            e  = $signed({3'b000, big[30:23]});
            if (s[27]) begin
                s = s >> 1;
                e = e + 11'sh001;
            end else begin
                // normalise left, at most 26 places
                for (i = 0; i < 26; i++) begin
                    if (!s[26] && s != 28'h000_0000) begin
                        s = s << 1;
                        e = e - 11'sh001;
                    end
                end
            end
            if (s == 28'h000_0000 || big[30:23] == 8'h00)
                fadd = 32'h0000_0000;
            else
                fadd = fpack(big[31], e, s[25:3]);
        end
    endfunction

    // truncating multiply
    function automatic logic [31:0] fmul(input logic [31:0] a,
                                         input logic [31:0] b);
        logic [47:0]        m;
        logic signed [10:0] e;
        logic [22:0]        fr;
        begin
            m = {1'b1, a[22:0]} * {1'b1, b[22:0]};
            e = $signed({3'b000, a[30:23]}) + $signed({3'b000, b[30:23]})
                - `MF_FP_BIAS;
            if (m[47]) begin
                e  = e + 11'sh001;
                fr = m[46:24];
            end else begin
                fr = m[45:23];
            end
            if (a[30:23] == 8'h00 || b[30:23] == 8'h00)
                fmul = {a[31] ^ b[31], 31'h0000_0000};
            else
                fmul = fpack(a[31] ^ b[31], e, fr);
        end
    endfunction

    // signed integer to float, exponent raised by sc
    function automatic logic [31:0] ffloat(input logic [31:0] x,
                                           input logic signed [7:0] sc);
        logic [31:0]        mag;
        logic [31:0]        nrm;
        logic [4:0]         msb;
        logic signed [10:0] e;
        integer             i;
        begin
            mag = x[31] ? (~x + 32'h0000_0001) : x;
            msb = 5'd0;
            for (i = 0; i < 32; i++) begin
                if (mag[i])
                    msb = i[4:0];
            end
            nrm = mag << (5'd31 - msb);
            e   = `MF_FP_BIAS + $signed({6'b00_0000, msb})
                  + $signed({{3{sc[7]}}, sc});
            if (mag == 32'h0000_0000)
                ffloat = 32'h0000_0000;
            else
                ffloat = fpack(x[31], e, nrm[30:8]);
        end
    endfunction

    // float to signed integer, truncated, saturating, scaled by sc
    function automatic logic [31:0] ffix(input logic [31:0] f,
                                         input logic signed [7:0] sc);
        logic signed [10:0] e;
        logic [54:0]        w;
        logic [31:0]        mag;
        begin
            e   = $signed({3'b000, f[30:23]}) - `MF_FP_BIAS
                  + $signed({{3{sc[7]}}, sc});
            w   = {31'h0000_0000, 1'b1, f[22:0]} << e[4:0];
            mag = w[54:23];
            if (f[30:23] == 8'h00 || e < 11'sh000)
                ffix = 32'h0000_0000;
            else if (e > `MF_FIX_MAXE)
                ffix = f[31] ? `MF_FIX_NEG : `MF_FIX_POS;
            else
                ffix = f[31] ? (~mag + 32'h0000_0001) : mag;
        end
    endfunction

    // ordering key so an unsigned compare orders floats
    function automatic logic [31:0] fkey(input logic [31:0] f);
        begin
            fkey = f[31] ? ~f : (f | `MF_SIGN_BIT);
        end
    endfunction

    logic [31:0] sum;   // ax + ay
    logic [31:0] dif;   // ax - ay

    // both halves see only the operands read this cycle
    always_comb begin
        prod_o = fmul(mx_i, my_i);
        sum    = fadd(ax_i, ay_i);
        dif    = fadd(ax_i, ay_i ^ `MF_SIGN_BIT);
        alu2_o = dif;
        case (alu_mode_i)
            mf_pkg::ALU_ADD:    alu_o = sum;
            mf_pkg::ALU_SUB:    alu_o = dif;
            mf_pkg::ALU_ADDSUB: alu_o = sum;
            mf_pkg::ALU_FLOAT:
                alu_o = ffloat(ax_i, ay_i[7:0]);
            mf_pkg::ALU_FIX:
                alu_o = ffix(ax_i, ay_i[7:0]);
            mf_pkg::ALU_AVG: begin
                // halve by one exponent step, flushing at the bottom
                if (sum[30:23] > 8'h01)
                    alu_o = {sum[31], sum[30:23] - 8'h01, sum[22:0]};
                else
                    alu_o = {sum[31], 31'h0000_0000};
            end
            mf_pkg::ALU_ABS:
                alu_o = {1'b0, ax_i[30:0]};
            mf_pkg::ALU_MAX:
                alu_o = (fkey(ax_i) >= fkey(ay_i)) ? ax_i : ay_i;
            mf_pkg::ALU_MIN:
                alu_o = (fkey(ax_i) <= fkey(ay_i)) ? ax_i : ay_i;
            default:
                alu_o = sum;
        endcase
    end

endmodule

// ---- core/mf_issue.sv ----
// multifunction compute issue: register file, fixed mac/alu, float unit

`timescale 1ns/1ps
`include "mf_defs.svh"

module mf_issue (
    input  wire logic                 clk_i,                // 50 MHz clock
    input  wire logic                 resetn_i,             // async reset
    input  wire logic                 issue_i,              // execute now
    input  wire logic                 fp_mode_i,            // 1 = float
    input  wire logic [2:0]           mult_mode_i,          // mult_mode_e
    input  wire logic [3:0]           alu_mode_i,           // alu_mode_e
    input  wire logic [`MF_SEL_W-1:0] mult_x_sel_i,         // r0..r3
    input  wire logic [`MF_SEL_W-1:0] mult_y_sel_i,         // r4..r7
    input  wire logic [`MF_SEL_W-1:0] alu_x_sel_i,          // r8..r11
    input  wire logic [`MF_SEL_W-1:0] alu_y_sel_i,          // r12..r15
    input  wire logic [`MF_IDX_W-1:0] mult_dest_reg_i,      // product dest
    input  wire logic [`MF_IDX_W-1:0] alu_dest_reg_i,       // alu dest
    input  wire logic [`MF_IDX_W-1:0] alu_second_dest_reg_i, // diff dest
    input  wire logic                 load_i,               // data bus write
    input  wire logic [`MF_IDX_W-1:0] load_addr_i,          // load index
    input  wire logic [`MF_DATA_W-1:0] load_data_i,         // load data
    input  wire logic [`MF_IDX_W-1:0] read_addr_i,          // read index
    output logic      [`MF_DATA_W-1:0] read_data_o,         // read data
    output logic      [`MF_ACC_W-1:0] fore_mult_accumulator_o, // accum
    output logic                      done_o                // issued pulse
);

    // stored state
    logic [`MF_DATA_W-1:0] regs      [`MF_REGS];  // data register file
    logic [`MF_DATA_W-1:0] next_regs [`MF_REGS];  // its next values
    logic [`MF_ACC_W-1:0]  acc;                   // fore accumulator
    logic [`MF_ACC_W-1:0]  next_acc;

    // port registers
    logic [`MF_DATA_W-1:0] next_read_data;
    logic                  done;
    logic                  next_done;

    logic [`MF_DATA_W-1:0] mx;        // multiplier x operand
    logic [`MF_DATA_W-1:0] my;        // multiplier y operand
    logic [`MF_DATA_W-1:0] ax;        // alu x operand
    logic [`MF_DATA_W-1:0] ay;        // alu y operand

    // raw signed product
    logic signed [63:0]    prod;
    // fractional product, sign extended
    logic [`MF_ACC_W-1:0]  prod_ext;
    // product or accumulator result
    logic [`MF_ACC_W-1:0]  mult_val;
    // mult_val rounded
    logic [`MF_ACC_W-1:0]  rnd_val;
    // product goes to the accumulator
    logic                  to_acc;

    // fixed sum, one guard bit
    logic [32:0]           fx_sum;
    logic [32:0]           fx_dif;    // fixed difference
    logic [`MF_DATA_W-1:0] fx_alu;    // fixed alu result

    logic [`MF_DATA_W-1:0] mult_res;  // value for mult_dest_reg
    logic [`MF_DATA_W-1:0] alu_res;   // value for alu_dest_reg
    logic [`MF_DATA_W-1:0] alu2_res;  // value for alu_second_dest_reg

    // float unit results
    logic [`MF_DATA_W-1:0] fp_prod;
    logic [`MF_DATA_W-1:0] fp_alu;
    logic [`MF_DATA_W-1:0] fp_alu2;

    logic                  mult_we;   // product writes a register
    logic                  alu2_we;   // dual add/sub second write

    // operand reads are hard wired to quarters; no crossing possible
    assign mx = regs[{`MF_Q_MULT_X, mult_x_sel_i}];
    assign my = regs[{`MF_Q_MULT_Y, mult_y_sel_i}];
    assign ax = regs[{`MF_Q_ALU_X, alu_x_sel_i}];
    assign ay = regs[{`MF_Q_ALU_Y, alu_y_sel_i}];

    // float datapath, purely combinational so it fits the one cycle
    mf_fp_unit u_fp (
        .mx_i       (mx),
        .my_i       (my),
        .ax_i       (ax),
        .ay_i       (ay),
        .alu_mode_i (alu_mode_i),
        .prod_o     (fp_prod),
        .alu_o      (fp_alu),
        .alu2_o     (fp_alu2)
    );

    // fixed multiplier: 1.31 x 1.31, shifted left once to 1.63
    // note: -1 x -1 wraps, the caller must avoid that pair
    always_comb begin
        prod     = $signed(mx) * $signed(my);
        prod_ext = {{16{prod[62]}}, prod[62:0], 1'b0};

        to_acc   = (mult_mode_i == mf_pkg::MAC_ACC) ||
                   (mult_mode_i == mf_pkg::MSUB_ACC);

        case (mult_mode_i)
            mf_pkg::MAC_ACC,
            mf_pkg::MAC_REG:
                mult_val = acc + prod_ext;
            mf_pkg::MSUB_ACC,
            mf_pkg::MSUB_REG:
                mult_val = acc - prod_ext;
            default:
                mult_val = prod_ext;
        endcase

        // round to nearest on the upper word of the fraction
        rnd_val = mult_val + `MF_RND_ADD;
    end

    // fixed alu: add, subtract, average, dual sum and difference
    always_comb begin
        fx_sum = {ax[31], ax} + {ay[31], ay};
        fx_dif = {ax[31], ax} - {ay[31], ay};

        case (alu_mode_i)
            mf_pkg::ALU_SUB: fx_alu = fx_dif[31:0];
            mf_pkg::ALU_AVG: fx_alu = fx_sum[32:1];
            default:         fx_alu = fx_sum[31:0];
        endcase
    end

    // result select for the two halves
    always_comb begin
        if (fp_mode_i) begin
            mult_res = fp_prod;
            alu_res  = fp_alu;
            alu2_res = fp_alu2;
            mult_we  = issue_i;
        end else begin
            mult_res = rnd_val[63:32];
            alu_res  = fx_alu;
            alu2_res = fx_dif[31:0];
            mult_we  = issue_i && !to_acc;
        end

        // dual form only
        alu2_we = issue_i && (alu_mode_i == mf_pkg::ALU_ADDSUB);
    end

    // per entry write select; on a clash the alu difference wins,
    // then the alu result, then the product, then a data bus load
    genvar gi;

    generate
        for (gi = 0; gi < `MF_REGS; gi++) begin : g_entry
            // next value of this entry
            always_comb begin
                if (alu2_we && alu_second_dest_reg_i == gi)
                    next_regs[gi] = alu2_res;
                else if (issue_i && alu_dest_reg_i == gi)
                    next_regs[gi] = alu_res;
                else if (mult_we && mult_dest_reg_i == gi)
                    next_regs[gi] = mult_res;
                else if (load_i && load_addr_i == gi)
                    next_regs[gi] = load_data_i;
                else
                    next_regs[gi] = regs[gi];
            end

            // all writes of one instruction land on the same edge
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    regs[gi] <= 32'h0000_0000;
                end else begin
                    regs[gi] <= next_regs[gi];
                end
            end
        end
    endgenerate

    // accumulator, read port and issue acknowledge
    always_comb begin
        next_acc = acc;
        if (issue_i && !fp_mode_i && to_acc)
            next_acc = mult_val;

        next_read_data = regs[read_addr_i];

        next_done      = issue_i;
    end

    // clocked state and ports
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acc         <= 80'h0000_0000_0000_0000_0000;
            read_data_o <= 32'h0000_0000;
            done        <= 1'b0;
        end else begin
            acc         <= next_acc;
            read_data_o <= next_read_data;
            done        <= next_done;
        end
    end

    // outputs are flops
    assign fore_mult_accumulator_o = acc;
    assign done_o                  = done;

endmodule

// ---- testbench/mf_issue_properties.sv ----
// concurrent checks on the multifunction issue ports
`timescale 1ns/1ps
`include "mf_defs.svh"

module mf_issue_properties (
    input wire logic                  clk_i,       // clock
    input wire logic                  resetn_i,    // async reset
    input wire logic                  issue_i,     // instruction strobe
    input wire logic                  fp_mode_i,   // float form
    input wire logic [2:0]            mult_mode_i, // mult half
    input wire logic                  load_i,      // register load
    input wire logic [`MF_IDX_W-1:0]  load_addr_i, // load index
    input wire logic [`MF_DATA_W-1:0] load_data_i, // load data
    input wire logic [`MF_IDX_W-1:0]  read_addr_i, // read index
    input wire logic [`MF_DATA_W-1:0] read_data_o, // read data
    input wire logic [`MF_ACC_W-1:0]  fore_mult_accumulator_o, // accum
    input wire logic                  done_o       // issue pulse
);
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    // fixed forms that send the product to a register, not the accumulator
    logic to_reg;
    assign to_reg = issue_i && !fp_mode_i
        && mult_mode_i != mf_pkg::MAC_ACC && mult_mode_i != mf_pkg::MSUB_ACC;

    // a load with nothing else, then the same index presented for reading
    sequence s_load_then_read;
        load_i && !issue_i ##1 read_addr_i == $past(load_addr_i);
    endsequence
    // a cycle without writes, then an unchanged read index
    sequence s_quiet_then_same;
        !load_i && !issue_i ##1 $stable(read_addr_i);
    endsequence

    a_done_follows: assert property (issue_i |=> done_o)
        else $error("done missing after issue");
    a_done_quiet: assert property (!issue_i |=> !done_o)
        else $error("done without issue");
    a_acc_idle: assert property (
        !issue_i |=> $stable(fore_mult_accumulator_o))
        else $error("accumulator moved while idle");
    a_acc_float: assert property (
        issue_i && fp_mode_i |=> $stable(fore_mult_accumulator_o))
        else $error("float form touched the accumulator");
    a_acc_to_reg: assert property (
        to_reg |=> $stable(fore_mult_accumulator_o))
        else $error("register form touched the accumulator");
    a_reset_clear: assert property (!$past(resetn_i) |->
        fore_mult_accumulator_o == '0 && !done_o && read_data_o == '0)
        else $error("state not cleared by reset");
    a_load_read: assert property (
        s_load_then_read |=> read_data_o == $past(load_data_i, 2))
        else $error("loaded word not read back");
    a_read_hold: assert property (
        s_quiet_then_same |=> $stable(read_data_o))
        else $error("register changed without a write");
endmodule

bind mf_issue mf_issue_properties u_props (
    .clk_i(clk_i), .resetn_i(resetn_i), .issue_i(issue_i),
    .fp_mode_i(fp_mode_i), .mult_mode_i(mult_mode_i), .load_i(load_i),
    .load_addr_i(load_addr_i), .load_data_i(load_data_i),
    .read_addr_i(read_addr_i), .read_data_o(read_data_o),
    .fore_mult_accumulator_o(fore_mult_accumulator_o), .done_o(done_o));

// ---- testbench/mf_seq_model.sv ----
// program sequencer model: issues instructions and register loads
`timescale 1ns/1ps

module mf_seq_model (
    input  wire logic   clk_i,       // device clock
    output logic        issue_o,     // instruction strobe
    output logic        fp_mode_o,   // float form
    output logic [2:0]  mult_mode_o, // mult half
    output logic [3:0]  alu_mode_o,  // alu half
    output logic [7:0]  sel_o,       // selects: mult x, mult y, alu x, alu y
    output logic [11:0] dest_o,      // dests: mult, alu, second
    output logic        load_o,      // load strobe
    output logic [3:0]  load_addr_o, // load index
    output logic [31:0] load_data_o  // load data
);
    // quiet from time zero
    initial begin
        {issue_o, fp_mode_o, mult_mode_o, alu_mode_o, sel_o, dest_o,
         load_o, load_addr_o, load_data_o} = '0;
    end

    // one load; strobe stays up so loads can run back to back
    task automatic ld(input logic [3:0] a, input logic [31:0] d);
        @(negedge clk_i);
        issue_o = 1'h0;
        load_o = 1'h1;
        load_addr_o = a;
        load_data_o = d;
        @(posedge clk_i);
    endtask

    // one instruction; strobe stays up so the next may follow at once
    task automatic iss(input logic fp, input logic [2:0] mm,
        input logic [3:0] am, input logic [7:0] s, input logic [11:0] d);
        @(negedge clk_i);
        load_o = 1'h0;
        issue_o = 1'h1;
        fp_mode_o = fp;
        mult_mode_o = mm;
        alu_mode_o = am;
        sel_o = s;
        dest_o = d;
        @(posedge clk_i);
    endtask

    // drop both strobes; released data turns over so stale words never match
    task automatic idle();
        @(negedge clk_i);
        issue_o = 1'h0;
        load_o = 1'h0;
        load_data_o = ~load_data_o;
    endtask
endmodule

// ---- testbench/tb_mf_issue.sv ----
// self-checking bench for the multifunction issue datapath
`timescale 1ns/1ps

module tb_mf_issue;
    logic        clk, resetn, issue, fp, load; // clock, reset, strobes
    logic [2:0]  mmode;                        // mult half
    logic [3:0]  amode, laddr, raddr;          // alu half, indexes
    logic [7:0]  sel;                          // quarter selects
    logic [11:0] dst;                          // destinations
    logic [31:0] ldata, rdata;                 // load and read words
    logic [79:0] acc;                          // accumulator
    logic        done;                         // issue pulse
    int          miscompares, cmp_count;       // tallies

    mf_issue u_mf_issue (
        .clk_i(clk), .resetn_i(resetn), .issue_i(issue), .fp_mode_i(fp),
        .mult_mode_i(mmode), .alu_mode_i(amode), .mult_x_sel_i(sel[7:6]),
        .mult_y_sel_i(sel[5:4]), .alu_x_sel_i(sel[3:2]),
        .alu_y_sel_i(sel[1:0]), .mult_dest_reg_i(dst[11:8]),
        .alu_dest_reg_i(dst[7:4]), .alu_second_dest_reg_i(dst[3:0]),
        .load_i(load), .load_addr_i(laddr), .load_data_i(ldata),
        .read_addr_i(raddr), .read_data_o(rdata),
        .fore_mult_accumulator_o(acc), .done_o(done));
    mf_seq_model u_seq (
        .clk_i(clk), .issue_o(issue), .fp_mode_o(fp), .mult_mode_o(mmode),
        .alu_mode_o(amode), .sel_o(sel), .dest_o(dst), .load_o(load),
        .load_addr_o(laddr), .load_data_o(ldata));

    initial clk = 1'h0;
    always #10 clk = ~clk;

    // q31 product; the left shift drops the duplicated sign bit
    function automatic logic [79:0] fprod(input logic [31:0] x, y);
        logic signed [63:0] p;
        p = $signed(x) * $signed(y);
        return {{16{p[62]}}, p[62:0], 1'h0};
    endfunction
    // round to nearest on the upper word
    function automatic logic [31:0] rnd(input logic [79:0] v);
        logic [79:0] s;
        s = v + 80'h0000_0000_8000_0000;
        return s[63:32];
    endfunction
    // fixed alu; average keeps the carry so it cannot overflow
    function automatic logic [31:0] falu(input logic [3:0] m,
        input logic [31:0] x, y);
        logic [32:0] s;
        s = {x[31], x} + {y[31], y};
        if (m == mf_pkg::ALU_SUB) return x - y;
        if (m == mf_pkg::ALU_AVG) return s[32:1];
        return s[31:0];
    endfunction

    // read a register back through the registered read port
    task automatic chk_reg(input logic [3:0] a, input logic [31:0] e);
        @(negedge clk);
        raddr = a;
        @(posedge clk);
        #1;
        cmp_count++;
        if (rdata !== e) begin
            miscompares++;
            $display("wrong value at %0t: r%0d %h not %h", $time, a, rdata, e);
        end
    endtask
    // compare the accumulator
    task automatic chk_acc(input logic [79:0] e);
        @(negedge clk);
        cmp_count++;
        if (acc !== e) begin
            miscompares++;
            $display("wrong value at %0t: acc %h not %h", $time, acc, e);
        end
    endtask

    // rounded multiply beside add, subtract and average, dests spread out
    task automatic t_mul();
        mf_pkg::alu_mode_e am [3] = '{mf_pkg::ALU_ADD, mf_pkg::ALU_SUB,
                                      mf_pkg::ALU_AVG};
        logic [3:0] md [3] = '{4'h2, 4'he, 4'h6};
        logic [3:0] ad [3] = '{4'h0, 4'hb, 4'hf};
        u_seq.ld(4'h1, 32'h4000_0001);
        u_seq.ld(4'h5, 32'h4000_0000);
        u_seq.ld(4'h9, 32'h0000_0005);
        u_seq.ld(4'hd, 32'hffff_fff8);
        for (int i = 0; i < 3; i++) begin
            u_seq.iss(1'h0, mf_pkg::MUL_REG, am[i], 8'h55, {md[i], ad[i], 4'h0});
            u_seq.idle();
            chk_reg(md[i], rnd(fprod(32'h4000_0001, 32'h4000_0000)));
            chk_reg(ad[i], falu(am[i], 32'h5, 32'hffff_fff8));
        end
        $display("t_mul finished");
    endtask

    // accumulate, subtract, and rounded register forms in one run
    task automatic t_acc();
        mf_pkg::mult_mode_e mm [7] = '{mf_pkg::MAC_ACC, mf_pkg::MAC_ACC,
            mf_pkg::MSUB_ACC, mf_pkg::MAC_REG, mf_pkg::MSUB_REG,
            mf_pkg::MSUB_ACC, mf_pkg::MSUB_ACC};
        logic [79:0] ea, p;
        logic [31:0] er;
        ea = '0;
        er = 32'h1234_5678;
        p = fprod(32'h4000_0001, 32'h4000_0000);
        u_seq.ld(4'h3, er);
        for (int i = 0; i < 7; i++) begin
            u_seq.iss(1'h0, mm[i], mf_pkg::ALU_AVG, 8'h55, 12'h3b0);
            u_seq.idle();
            case (mm[i])
                mf_pkg::MAC_ACC: ea = ea + p;
                mf_pkg::MSUB_ACC: ea = ea - p;
                mf_pkg::MAC_REG: er = rnd(ea + p);
                default: er = rnd(ea - p);
            endcase
            chk_acc(ea);
            chk_reg(4'h3, er);
            chk_reg(4'hb, 32'hffff_fffe);
        end
        $display("t_acc finished");
    endtask

    // rounded multiply with sum and difference to two registers
    task automatic t_dual();
        u_seq.iss(1'h0, mf_pkg::MUL_REG, mf_pkg::ALU_ADDSUB, 8'h55, 12'h678);
        u_seq.idle();
        chk_reg(4'h6, rnd(fprod(32'h4000_0001, 32'h4000_0000)));
        chk_reg(4'h7, 32'hffff_fffd);
        chk_reg(4'h8, 32'h0000_000d);
        $display("t_dual finished");
    endtask

    // float multiply beside every alu mode
    task automatic t_float();
        logic [31:0] ex [9] = '{32'hbf00_0000, 32'hbfc0_0000, 32'hbe80_0000,
            32'hbf00_0000, 32'h4140_0000, 32'h0000_0003, 32'h3f80_0000,
            32'h3f00_0000, 32'hbf80_0000};
        u_seq.ld(4'h0, 32'h4000_0000);
        u_seq.ld(4'h4, 32'h4040_0000);
        for (int i = 0; i < 9; i++) begin
            u_seq.ld(4'h8, i == 4 ? 32'h0000_0003 :
                           i == 5 ? 32'h4140_0000 : 32'hbf80_0000);
            u_seq.ld(4'hc, i == 4 ? 32'h0000_0002 :
                           i == 5 ? 32'hffff_fffe : 32'h3f00_0000);
            u_seq.iss(1'h1, 3'h0, 4'(i), 8'h00, 12'h123);
            u_seq.idle();
            chk_reg(4'h1, 32'h40c0_0000);
            chk_reg(4'h2, ex[i]);
            if (i == 3) chk_reg(4'h3, 32'hbfc0_0000);
        end
        $display("t_float finished");
    endtask

    // back to back: old operands within one cycle, new ones in the next
    task automatic t_order();
        u_seq.ld(4'h0, 32'h4000_0000);
        u_seq.ld(4'h4, 32'h4000_0000);
        u_seq.ld(4'h8, 32'h0000_0010);
        u_seq.ld(4'hc, 32'h0000_0001);
        u_seq.iss(1'h0, mf_pkg::MUL_REG, mf_pkg::ALU_ADD, 8'h00, 12'h890);
        u_seq.iss(1'h0, mf_pkg::MUL_REG, mf_pkg::ALU_ADD, 8'h00, 12'haa0);
        u_seq.idle();
        chk_reg(4'h8, 32'h2000_0000);
        chk_reg(4'h9, 32'h0000_0011);
        chk_reg(4'ha, 32'h2000_0001);
        $display("t_order finished");
    endtask

    // report counts and the verdict, then stop
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog: the run needs well under a thousand cycles
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end

    // reset for ten cycles, check cleared state, then the scenarios
    initial begin
        miscompares = 0;
        cmp_count = 0;
        resetn = 1'h0;
        raddr = 4'h0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        resetn = 1'h1;
        chk_acc('0);
        chk_reg(4'h5, 32'h0000_0000);
        t_mul();
        t_acc();
        t_dual();
        t_float();
        t_order();
        finish_test();
    end
endmodule
